// File: sim/rtb_cmd_props.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_cmd_chk (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  // Link
  input wire logic        rx_sof_in,
  input wire logic        rx_bit_valid_in,
  input wire logic        rx_bit_in,
  input wire logic        rx_eof_in,
  input wire logic        slot_mark_in,
  input wire logic        tx_ready_in,
  input wire logic        tx_valid_out,
  input wire logic        tx_bit_out,
  input wire logic        tx_dual_out,
  input wire logic        tx_last_out,
  // Register port
  input wire logic [4:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out
);
  logic rx_act_q;
  logic in_rsp_q;
  wire  acc = tx_valid_out & tx_ready_in;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Request in flight and reply in progress
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_act_q <= 1'b0;
      in_rsp_q <= 1'b0;
    end else begin
      rx_act_q <= rx_sof_in | (rx_act_q & ~rx_eof_in);
      in_rsp_q <= ~rx_sof_in & ((acc & ~tx_last_out) | (in_rsp_q & ~(acc & tx_last_out)));
    end
  end
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in && !rx_sof_in |=>
    tx_valid_out && $stable({tx_bit_out, tx_dual_out, tx_last_out})) else $error("reply bit changed while stalled");
  a_dual_first: assert property (acc && !tx_dual_out && !tx_last_out |=> !tx_dual_out)
    else $error("dual bit after coded bit");
  a_last_manch: assert property (tx_valid_out && tx_last_out |-> !tx_dual_out)
    else $error("last bit dual coded");
  a_last_ends: assert property (acc && tx_last_out |=> !tx_valid_out)
    else $error("reply runs past last bit");
  a_no_spont: assert property (tx_valid_out && !$past(tx_valid_out) && !in_rsp_q |->
    $past(rx_eof_in, 2) || $past(rx_eof_in, 3) || $past(slot_mark_in, 3)) else $error("reply without request");
  a_sof_abort: assert property (rx_sof_in |=> !tx_valid_out)
    else $error("reply not aborted by start");
  a_rx_silent: assert property (rx_act_q |-> !tx_valid_out)
    else $error("reply during request");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");
  c_stall: cover property (tx_valid_out && !tx_ready_in);
  c_dual: cover property (acc && tx_dual_out);
  c_done: cover property (acc && tx_last_out);
  c_slot: cover property (slot_mark_in ##3 tx_valid_out);
endmodule // rtb_cmd_chk
bind rtb_cmd rtb_cmd_chk u_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .rx_sof_in(rx_sof_in), .rx_bit_valid_in(rx_bit_valid_in),
  .rx_bit_in(rx_bit_in), .rx_eof_in(rx_eof_in), .slot_mark_in(slot_mark_in), .tx_ready_in(tx_ready_in),
  .tx_valid_out(tx_valid_out), .tx_bit_out(tx_bit_out), .tx_dual_out(tx_dual_out), .tx_last_out(tx_last_out),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out));
`default_nettype wire

// File: sim/rtb_rdr.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_rdr (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  input  wire logic         slow_in,
  // Request side
  output var  logic         rx_sof_out,
  output var  logic         rx_bit_valid_out,
  output var  logic         rx_bit_out,
  output var  logic         rx_eof_out,
  output var  logic         slot_mark_out,
  // Reply side
  output var  logic         tx_ready_out,
  input  wire logic         tx_valid_in,
  input  wire logic         tx_bit_in,
  input  wire logic         tx_dual_in,
  input  wire logic         tx_last_in,
  // Captured reply
  output var  logic [127:0] bits_out,
  output var  logic [127:0] dual_out,
  output var  logic [7:0]   cnt_out,
  output var  logic         done_out
);
  logic tgl_q;
  initial begin
    rx_sof_out = 1'b0;
    rx_bit_valid_out = 1'b0;
    rx_bit_out = 1'b0;
    rx_eof_out = 1'b0;
    slot_mark_out = 1'b0;
  end
  // Slow mode accepts every other cycle
  always @* tx_ready_out = ~slow_in | tgl_q;
  // Reply capture, cleared at each request start
  always @(posedge clk_sys_in) begin
    tgl_q <= rst_in ? 1'b0 : ~tgl_q;
    if (rx_sof_out) begin
      cnt_out <= 8'h00;
      done_out <= 1'b0;
      bits_out <= 128'h0;
      dual_out <= 128'h0;
    end else if (tx_valid_in && tx_ready_out) begin
      bits_out <= {bits_out[126:0], tx_bit_in};
      dual_out <= {dual_out[126:0], tx_dual_in};
      cnt_out <= cnt_out + 8'h01;
      done_out <= tx_last_in;
    end
  end
  // Frame: start, bits MSB first with check appended, end
  task automatic send(input logic [127:0] v, input int n, input bit bad);
    logic [15:0]  c;
    logic [143:0] s;
    c = 16'h0000;
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
    s = {v, c ^ {15'h0, bad}};
    @(posedge clk_sys_in);
    rx_sof_out <= 1'b1;
    for (int i = n + 15; i >= 0; i--) begin
      @(posedge clk_sys_in);
      rx_sof_out <= 1'b0;
      rx_bit_valid_out <= 1'b1;
      rx_bit_out <= s[i];
      @(posedge clk_sys_in);
      rx_bit_valid_out <= 1'b0;
      rx_bit_out <= ~s[i];
    end
    @(posedge clk_sys_in);
    rx_eof_out <= 1'b1;
    @(posedge clk_sys_in);
    rx_eof_out <= 1'b0;
  endtask
  // Slot markers, one pulse every two cycles
  task automatic marks(input int k);
    repeat (k) begin
      @(posedge clk_sys_in);
      slot_mark_out <= 1'b1;
      @(posedge clk_sys_in);
      slot_mark_out <= 1'b0;
    end
  endtask
endmodule // rtb_rdr
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`include "rtb_defines.vh"
`default_nettype none
module tb;
  localparam logic [47:0] UID = 48'hc4e1_5a3c_9617;
  localparam logic [31:0] M2  = 32'h1234_abcd;
  localparam logic [31:0] M3  = 32'hf0e1_d2c3;
  logic         clk_sys_in;
  logic         rst_in;
  logic         slow;
  logic         sof, bvld, rbit, eof, slot, rdy, tvld, tbit, tdual, tlast;
  logic [4:0]   reg_addr;
  logic [31:0]  reg_wdata, reg_rdata;
  logic         reg_wr, reg_rd;
  logic [127:0] rbits, rdual;
  logic [7:0]   rcnt;
  logic         rdone;
  int           error_cnt = 0;
  int           checks = 0;
  rtb_cmd DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .rx_sof_in(sof), .rx_bit_valid_in(bvld),
    .rx_bit_in(rbit), .rx_eof_in(eof), .slot_mark_in(slot), .tx_ready_in(rdy), .tx_valid_out(tvld),
    .tx_bit_out(tbit), .tx_dual_out(tdual), .tx_last_out(tlast), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
  rtb_rdr u_rdr (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .slow_in(slow), .rx_sof_out(sof),
    .rx_bit_valid_out(bvld), .rx_bit_out(rbit), .rx_eof_out(eof), .slot_mark_out(slot), .tx_ready_out(rdy),
    .tx_valid_in(tvld), .tx_bit_in(tbit), .tx_dual_in(tdual), .tx_last_in(tlast), .bits_out(rbits),
    .dual_out(rdual), .cnt_out(rcnt), .done_out(rdone));
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Status fields: state, lock bit of a block
  task automatic st(input logic [1:0] e);
    logic [31:0] d;
    rd(5'h04, d);
    chk(d[1:0], e);
  endtask
  task automatic lkb(input logic [7:0] b, input logic e);
    logic [31:0] d;
    wr(5'h10, {24'h0, b});
    rd(5'h04, d);
    chk(d[4], e);
  endtask
  // Reference check sum, MSB first
  function automatic logic [15:0] crc16(input logic [127:0] v, input int n);
    crc16 = 16'h0000;
    for (int i = n - 1; i >= 0; i--) crc16 = {crc16[14:0], 1'b0} ^ ((crc16[15] ^ v[i]) ? 16'h1021 : 16'h0000);
  endfunction
  // Reply bits, count and coding judged
  task automatic got(input logic [127:0] e, input int en, input int nd);
    logic [127:0] dm;
    dm = ((128'h1 << nd) - 128'h1) << (en - nd);
    if (en == 0) repeat (300) @(posedge clk_sys_in);
    else for (int i = 0; i < 2000 && rdone !== 1'b1; i++) @(posedge clk_sys_in);
    #1;
    chk(rcnt, en);
    chk(rbits, e);
    chk(rdual, dm);
  endtask
  // One request, then its reply
  task automatic req(input logic [127:0] v, input int n, input bit bad, input logic [127:0] e, input int en,
                     input int nd);
    u_rdr.send(v, n, bad);
    got(e, en, nd);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rd(5'h00, d);
    chk(d, 32'h0);
    st(2'h0);
    wr(5'h08, UID[31:0]);
    wr(5'h0c, {16'h0, UID[47:32]});
    rd(5'h0c, d);
    chk(d[15:0], UID[47:32]);
    rd(5'h1c, d);
    chk(d, 32'h0);
    wr(5'h10, 32'h2);
    wr(5'h14, M2);
  endtask
  task automatic t_write;
    logic [31:0] d;
    req({5'b00100, `RTB_CMD_WRITE, 8'h03, M3}, 51, 0, 1'b0, 1, 0);
    wr(5'h10, 32'h3);
    rd(5'h14, d);
    chk(d, M3);
    req({5'b00100, `RTB_CMD_WRITE, 8'h19, M3}, 51, 0, {1'b1, 3'h1}, 4, 0);
    // Reply check sum appended
    wr(5'h00, 32'h1);
    req({5'b00100, `RTB_CMD_WRITE, 8'h19, M3}, 51, 0, {4'b1001, crc16(4'b1001, 4)}, 20, 0);
    wr(5'h00, 32'h0);
  endtask
  task automatic t_inv;
    slow <= 1'b1;
    req({5'b10110, `RTB_CMD_READ, 6'd0, 8'h02, 8'h01}, 33, 0, {UID, 1'b0, M2, M3}, 113, 48);
    slow <= 1'b0;
    req({5'b10110, `RTB_CMD_READ, 6'd0, 8'h18, 8'h01}, 33, 0, {UID, 1'b1, 3'h1}, 52, 48);
    req({5'b10111, `RTB_CMD_READ, 6'd0, 8'h02, 8'h00}, 33, 0, 0, 0, 0);
    req({5'b10110, `RTB_CMD_READ, 6'd4, 4'h0, 8'h02, 8'h00}, 37, 0, 0, 0, 0);
    req({5'b10110, `RTB_CMD_READ, 6'd0, 8'h02, 8'h00}, 33, 1, 0, 0, 0);
    // Sixteen slots: reply only in the slot named by the top identifier bits
    u_rdr.send({5'b00110, `RTB_CMD_READ, 6'd0, 8'h02, 8'h00}, 33, 0);
    u_rdr.marks(UID[47:44] - 1);
    repeat (4) @(posedge clk_sys_in);
    chk(rcnt, 8'h00);
    u_rdr.marks(1);
    got({UID, 1'b0, M2}, 81, 48);
  endtask
  task automatic t_lock;
    logic [31:0] d;
    req({5'b00100, `RTB_CMD_LOCK, 8'h03}, 19, 0, 1'b0, 1, 0);
    req({5'b00100, `RTB_CMD_WRITE, 8'h03, M2}, 51, 0, {1'b1, 3'h2}, 4, 0);
    rd(5'h14, d);
    chk(d, M3);
    req({5'b00100, `RTB_CMD_LOCK, 8'hfe}, 19, 0, 1'b0, 1, 0);
    lkb(8'hfe, 1'b1);
    // Password active, not logged in, then logged in
    wr(5'h00, 32'h2);
    req({5'b00100, `RTB_CMD_LOCK, 8'h05}, 19, 0, {1'b1, 3'h3}, 4, 0);
    wr(5'h00, 32'h6);
    req({5'b00100, `RTB_CMD_LOCK, 8'h05}, 19, 0, 1'b0, 1, 0);
    wr(5'h00, 32'h8);
    req({5'b00100, `RTB_CMD_LOCK, 8'h20}, 19, 0, 1'b0, 1, 0);
    lkb(8'h19, 1'b1);
    lkb(8'h36, 1'b1);
    lkb(8'h18, 1'b0);
  endtask
  task automatic t_sel;
    logic [31:0] d;
    req({5'b10100, `RTB_CMD_SELECT, UID ^ 48'h1}, 59, 0, 0, 0, 0);
    st(2'h0);
    req({5'b10100, `RTB_CMD_SELECT, UID}, 59, 0, 1'b0, 1, 0);
    st(2'h1);
    req({5'b01100, `RTB_CMD_WRITE, 8'h04, M2}, 51, 0, 1'b0, 1, 0);
    req({5'b10110, `RTB_CMD_READ, 6'd0, 8'h02, 8'h00}, 33, 0, 0, 0, 0);
    req({5'b10100, `RTB_CMD_SELECT, UID ^ 48'h8000}, 59, 0, 0, 0, 0);
    st(2'h2);
    req({5'b10100, `RTB_CMD_SELECT, UID ^ 48'h1}, 59, 0, 0, 0, 0);
    st(2'h2);
    req({5'b00100, `RTB_CMD_WRITE, 8'h04, M3}, 51, 0, 0, 0, 0);
    wr(5'h10, 32'h4);
    rd(5'h14, d);
    chk(d, M2);
    req({5'b10100, `RTB_CMD_SELECT, UID}, 59, 0, 1'b0, 1, 0);
    st(2'h1);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    error_cnt++;
    stop_test;
  end
  // Main sequence
  initial begin
    rst_in = 1'b1;
    slow = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_regs;
    t_write;
    t_inv;
    t_lock;
    t_sel;
    stop_test;
  end
endmodule // tb
`default_nettype wire

// File: verilog/rtb_cmd.v
// Notes on behaviour
// - inventory flag one selects inventory read
// - inventory CRC, flag or length error means silence
// - identifier remainder dual coded, rest Manchester
// - reply: id remainder, flag zero, blocks, CRC
// - inventory error: id, flag, code, CRC
// - good write stores block then replies
// - write/lock/select success: flag zero, CRC
// - locked block refuses every later write command
// - lockable singly: 00h-18h, FEh, FFh
// - large variant locks 19h-36h as group
// - with password, lock needs login first
// - matching select enters selected and replies
// - ready/quiet mismatch keeps state, silent
// - selected mismatch goes quiet, silent
// - block count is number minus one
// - CRC 1021h preset 0000h checked first
`timescale 1ns/1ps
`include "rtb_defines.vh"
`default_nettype none
module rtb_cmd (
  // Clock and reset
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // Request bits from demodulator
  input  wire        rx_sof_in,
  input  wire        rx_bit_valid_in,
  input  wire        rx_bit_in,
  input  wire        rx_eof_in,
  input  wire        slot_mark_in,
  // Response bits to modulator
  input  wire        tx_ready_in,
  output reg         tx_valid_out,
  output reg         tx_bit_out,
  output reg         tx_dual_out,
  output reg         tx_last_out,
  // Register port
  input  wire [4:0]  reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  output reg  [31:0] reg_rdata_out
);
  localparam S_IDLE = 2'd0, S_SLOT = 2'd1, S_SEND = 2'd2;
  localparam D_READY = 2'd0, D_SEL = 2'd1, D_QUIET = 2'd2;
  localparam P_UID = 3'd0, P_ERR = 3'd1, P_CODE = 3'd2, P_DATA = 3'd3, P_CRC = 3'd4, P_DONE = 3'd5;

  reg [31:0]  mem [0:255];
  reg [255:0] lock_q;
  reg [127:0] rx_buf_q;
  reg [7:0]   rx_len_q;
  reg [15:0]  rx_crc_q;
  reg         rx_ovf_q;
  reg [47:0]  uid_q;
  reg [3:0]   ctrl_q;
  reg [7:0]   maddr_q;
  reg [1:0]   fsm_q;
  reg [1:0]   dev_q;
  reg [2:0]   ph_q;
  reg [5:0]   cnt_q;
  reg [47:0]  uid_sh_q;
  reg [31:0]  word_q;
  reg [15:0]  crc_tx_q;
  reg [15:0]  crc_sh_q;
  reg         err_q;
  reg [2:0]   code_q;
  reg [7:0]   blk_q;
  reg [8:0]   left_q;
  reg [3:0]   slot_q;
  reg [3:0]   slot_tgt_q;

  // CRC step, one bit, MSB first
  function [15:0] crc_upd;
    input [15:0] c;
    input        b;
    begin
      crc_upd = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `RTB_CRC_POLY : 16'h0000);
    end
  endfunction

  //--------------------------------------------------
  // Request field decode
  //--------------------------------------------------
  wire [127:0] msg    = rx_buf_q << (`RTB_RX_MAX - rx_len_q);
  wire [4:0]   flags  = msg[127:123];
  wire [5:0]   cmd    = msg[122:117];
  wire         crc_on = flags[`RTB_F_CRC];
  wire [7:0]   body   = rx_len_q - (crc_on ? `RTB_LEN_CRC : 8'h00);
  wire         crc_ok = !crc_on || (rx_crc_q == 16'h0000);
  wire [5:0]   mlen   = msg[116:111];
  wire [127:0] inv_sh = msg << mlen;
  wire [47:0]  m_val  = msg[110:63] >> (`RTB_MASK_MAX - mlen);
  wire [47:0]  m_uid  = uid_q >> (`RTB_MASK_MAX - mlen);
  wire [7:0]   i_fst  = inv_sh[110:103];
  wire [7:0]   i_cnt  = inv_sh[102:95];
  wire [47:0]  i_rest = uid_q << mlen;
  wire         adr    = flags[`RTB_F_ADR];
  wire [127:0] w_sh   = adr ? (msg << `RTB_LEN_UID) : msg;
  wire [47:0]  r_uid  = msg[116:69];
  wire [7:0]   a_blk  = w_sh[116:109];
  wire [31:0]  a_dat  = w_sh[108:77];
  wire         uid_eq = (r_uid == uid_q);
  wire [7:0]   u_last = ctrl_q[`RTB_C_LARGE] ? `RTB_BLK_GRP_LAST : `RTB_BLK_LO_LAST;
  wire [7:0]   a_xlen = adr ? `RTB_LEN_UID : 8'h00;

  // Permitted forms per command and device state
  wire ok_base = crc_ok && !rx_ovf_q && !flags[`RTB_F_RFU];
  wire is_inv  = (cmd == `RTB_CMD_READ) && flags[`RTB_F_INV];
  wire f_inv   = is_inv && !flags[`RTB_F_SEL] && (dev_q == D_READY)
                 && (mlen <= `RTB_MASK_MAX) && (body == `RTB_LEN_INV0 + {2'b00, mlen});
  wire f_adr   = !flags[`RTB_F_INV] && (((flags[4:3] == 2'b00) && (dev_q == D_READY))
                 || ((flags[4:3] == 2'b10) && (dev_q == D_READY) && uid_eq)
                 || ((flags[4:3] == 2'b01) && (dev_q == D_SEL)));
  wire f_wr    = (cmd == `RTB_CMD_WRITE) && f_adr && (body == `RTB_LEN_WR + a_xlen);
  wire f_lk    = (cmd == `RTB_CMD_LOCK) && f_adr && (body == `RTB_LEN_LK + a_xlen);
  wire f_sel   = (cmd == `RTB_CMD_SELECT) && (flags[4:3] == 2'b10) && !flags[`RTB_F_INV]
                 && (body == `RTB_LEN_SEL);
  wire go      = rx_eof_in && (fsm_q == S_IDLE) && ok_base;

  // Range and lock checks
  wire inv_rng = ({1'b0, i_fst} + {1'b0, i_cnt}) > {1'b0, u_last};
  wire in_grp  = (a_blk >= `RTB_BLK_GRP_FST) && (a_blk <= `RTB_BLK_GRP_LAST);
  wire lk_ok   = (a_blk <= `RTB_BLK_LO_LAST) || (a_blk == `RTB_BLK_SYS_A)
                 || (a_blk == `RTB_BLK_SYS_B) || (ctrl_q[`RTB_C_LARGE] && in_grp);
  wire lk_auth = !ctrl_q[`RTB_C_PWD] || ctrl_q[`RTB_C_LOGIN];
  wire wr_err  = (a_blk > u_last) || lock_q[a_blk];
  wire wr_do   = go && f_wr && !wr_err;
  wire lk_do   = go && f_lk && lk_ok && lk_auth;

  //--------------------------------------------------
  // Request receiver with running CRC
  //--------------------------------------------------
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_buf_q <= 128'h0;
      rx_len_q <= 8'h00;
      rx_crc_q <= `RTB_CRC_INIT;
      rx_ovf_q <= 1'b0;
    end else if (rx_sof_in) begin
      rx_buf_q <= 128'h0;
      rx_len_q <= 8'h00;
      rx_crc_q <= `RTB_CRC_INIT;
      rx_ovf_q <= 1'b0;
    end else if (rx_bit_valid_in) begin
      rx_buf_q <= {rx_buf_q[126:0], rx_bit_in};
      rx_crc_q <= crc_upd(rx_crc_q, rx_bit_in);
      if (rx_len_q == `RTB_RX_MAX)
        rx_ovf_q <= 1'b1;
      else
        rx_len_q <= rx_len_q + 8'h01;
    end
  end

  //--------------------------------------------------
  // Memory and lock bits
  //--------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (wr_do)
      mem[a_blk] <= a_dat;
    else if (reg_wr_in && (reg_addr_in == `RTB_REG_MDATA))
      mem[maddr_q] <= reg_wdata_in;
  end

  // Group lock sets every block of the range
  genvar g;
  generate
    for (g = 0; g < 256; g = g + 1) begin : g_lock
      always @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
          lock_q[g] <= 1'b0;
        else if (lk_do && ((a_blk == g) || (in_grp && (g >= `RTB_BLK_GRP_FST) && (g <= `RTB_BLK_GRP_LAST))))
          lock_q[g] <= 1'b1;
      end
    end
  endgenerate

  //--------------------------------------------------
  // Next response bit and CRC
  //--------------------------------------------------
  reg nb;
  always @* begin
    case (ph_q)
      P_UID:   nb = uid_sh_q[47];
      P_ERR:   nb = err_q;
      P_CODE:  nb = code_q[2];
      P_DATA:  nb = word_q[31];
      P_CRC:   nb = crc_sh_q[15];
      default: nb = 1'b0;
    endcase
  end
  wire [15:0] crc_nx = crc_upd(crc_tx_q, nb);
  wire        adv    = (fsm_q == S_SEND) && (!tx_valid_out || tx_ready_in);
  wire        crct   = ctrl_q[`RTB_C_CRCT];

  //--------------------------------------------------
  // Command execution, slots and response sequencer
  //--------------------------------------------------
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fsm_q <= S_IDLE;
      dev_q <= D_READY;
      ph_q <= P_ERR;
      cnt_q <= 6'h00;
      uid_sh_q <= 48'h0;
      word_q <= 32'h0;
      crc_tx_q <= `RTB_CRC_INIT;
      crc_sh_q <= 16'h0000;
      err_q <= 1'b0;
      code_q <= 3'h0;
      blk_q <= 8'h00;
      left_q <= 9'h000;
      slot_q <= 4'h0;
      slot_tgt_q <= 4'h0;
      tx_valid_out <= 1'b0;
      tx_bit_out <= 1'b0;
      tx_dual_out <= 1'b0;
      tx_last_out <= 1'b0;
    end else if (rx_sof_in) begin
      // New request aborts any pending reply
      fsm_q <= S_IDLE;
      tx_valid_out <= 1'b0;
      tx_last_out <= 1'b0;
    end else if (go) begin
      crc_tx_q <= `RTB_CRC_INIT;
      ph_q <= P_ERR;
      err_q <= 1'b0;
      if (f_inv && (m_val == m_uid)) begin
        // Identifier remainder first, then flag
        uid_sh_q <= i_rest;
        cnt_q <= `RTB_MASK_MAX - mlen;
        ph_q <= (mlen == `RTB_MASK_MAX) ? P_ERR : P_UID;
        err_q <= inv_rng;
        code_q <= `RTB_ERR_RANGE;
        blk_q <= i_fst;
        left_q <= {1'b0, i_cnt} + 9'h001;
        slot_q <= 4'h0;
        slot_tgt_q <= i_rest[47:44];
        fsm_q <= adr ? S_SEND : S_SLOT;
      end else if (f_wr) begin
        err_q <= wr_err;
        code_q <= (a_blk > u_last) ? `RTB_ERR_RANGE : `RTB_ERR_LOCKED;
        left_q <= 9'h000;
        fsm_q <= S_SEND;
      end else if (f_lk) begin
        err_q <= !(lk_ok && lk_auth);
        code_q <= lk_ok ? `RTB_ERR_AUTH : `RTB_ERR_RANGE;
        left_q <= 9'h000;
        fsm_q <= S_SEND;
      end else if (f_sel) begin
        left_q <= 9'h000;
        if (uid_eq) begin
          dev_q <= D_SEL;
          fsm_q <= S_SEND;
        end else if (dev_q == D_SEL) begin
          dev_q <= D_QUIET;
        end
      end
    end else if (fsm_q == S_SLOT) begin
      // Wait for own slot among sixteen
      if (slot_q == slot_tgt_q)
        fsm_q <= S_SEND;
      else if (slot_mark_in)
        slot_q <= slot_q + 4'h1;
    end else if (adv) begin
      tx_valid_out <= (ph_q != P_DONE);
      tx_bit_out <= nb;
      tx_dual_out <= (ph_q == P_UID);
      tx_last_out <= 1'b0;
      if (ph_q != P_CRC)
        crc_tx_q <= crc_nx;
      case (ph_q)
        P_UID: begin
          uid_sh_q <= {uid_sh_q[46:0], 1'b0};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01)
            ph_q <= P_ERR;
        end
        P_ERR: begin
          if (err_q) begin
            ph_q <= P_CODE;
            cnt_q <= 6'd3;
          end else if (left_q != 9'h000) begin
            ph_q <= P_DATA;
            word_q <= mem[blk_q];
            cnt_q <= 6'd32;
          end else if (crct) begin
            ph_q <= P_CRC;
            crc_sh_q <= crc_nx;
            cnt_q <= 6'd16;
          end else begin
            ph_q <= P_DONE;
            tx_last_out <= 1'b1;
          end
        end
        P_CODE: begin
          code_q <= {code_q[1:0], 1'b0};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            ph_q <= crct ? P_CRC : P_DONE;
            crc_sh_q <= crc_nx;
            cnt_q <= 6'd16;
            tx_last_out <= !crct;
          end
        end
        P_DATA: begin
          word_q <= {word_q[30:0], 1'b0};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            left_q <= left_q - 9'h001;
            blk_q <= blk_q + 8'h01;
            cnt_q <= 6'd32;
            if (left_q != 9'h001) begin
              word_q <= mem[blk_q + 8'h01];
            end else begin
              ph_q <= crct ? P_CRC : P_DONE;
              crc_sh_q <= crc_nx;
              cnt_q <= 6'd16;
              tx_last_out <= !crct;
            end
          end
        end
        P_CRC: begin
          crc_sh_q <= {crc_sh_q[14:0], 1'b0};
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) begin
            ph_q <= P_DONE;
            tx_last_out <= 1'b1;
          end
        end
        default: fsm_q <= S_IDLE;
      endcase
    end
  end

  //--------------------------------------------------
  // Register port
  //--------------------------------------------------
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `RTB_CTRL_RST;
      uid_q <= 48'h0;
      maddr_q <= 8'h00;
      reg_rdata_out <= 32'h0;
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `RTB_REG_CTRL:  ctrl_q <= reg_wdata_in[3:0];
          `RTB_REG_UIDL:  uid_q[31:0] <= reg_wdata_in;
          `RTB_REG_UIDH:  uid_q[47:32] <= reg_wdata_in[15:0];
          `RTB_REG_MADDR: maddr_q <= reg_wdata_in[7:0];
          default:        ;
        endcase
      end
      reg_rdata_out <= 32'h0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `RTB_REG_CTRL:  reg_rdata_out <= {28'h0, ctrl_q};
          `RTB_REG_STAT:  reg_rdata_out <= {27'h0, lock_q[maddr_q], fsm_q, dev_q};
          `RTB_REG_UIDL:  reg_rdata_out <= uid_q[31:0];
          `RTB_REG_UIDH:  reg_rdata_out <= {16'h0, uid_q[47:32]};
          `RTB_REG_MADDR: reg_rdata_out <= {24'h0, maddr_q};
          `RTB_REG_MDATA: reg_rdata_out <= mem[maddr_q];
          default:        reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end
endmodule // rtb_cmd
`default_nettype wire

// File: verilog/rtb_defines.vh
`ifndef RTB_DEFINES_VH
`define RTB_DEFINES_VH
// Command codes
`define RTB_CMD_READ    6'h12
`define RTB_CMD_WRITE   6'h14
`define RTB_CMD_LOCK    6'h16
`define RTB_CMD_SELECT  6'h18
// Request flag positions (first received flag bit is bit 4)
`define RTB_F_ADR   4
`define RTB_F_SEL   3
`define RTB_F_CRC   2
`define RTB_F_INV   1
`define RTB_F_RFU   0
// Request lengths in bits without CRC
`define RTB_LEN_INV0   8'd33
`define RTB_LEN_WR     8'd51
`define RTB_LEN_LK     8'd19
`define RTB_LEN_SEL    8'd59
`define RTB_LEN_UID    8'd48
`define RTB_LEN_CRC    8'd16
`define RTB_RX_MAX     8'd128
`define RTB_MASK_MAX   6'd48
// Block ranges
`define RTB_BLK_LO_LAST  8'h18
`define RTB_BLK_GRP_FST  8'h19
`define RTB_BLK_GRP_LAST 8'h36
`define RTB_BLK_SYS_A    8'hfe
`define RTB_BLK_SYS_B    8'hff
// Check sum
`define RTB_CRC_POLY   16'h1021
`define RTB_CRC_INIT   16'h0000
// Error codes (3 bits)
`define RTB_ERR_RANGE  3'h1
`define RTB_ERR_LOCKED 3'h2
`define RTB_ERR_AUTH   3'h3
// Register offsets
`define RTB_REG_CTRL   5'h00
`define RTB_REG_STAT   5'h04
`define RTB_REG_UIDL   5'h08
`define RTB_REG_UIDH   5'h0c
`define RTB_REG_MADDR  5'h10
`define RTB_REG_MDATA  5'h14
// Control bits and reset value
`define RTB_C_CRCT   0
`define RTB_C_PWD    1
`define RTB_C_LOGIN  2
`define RTB_C_LARGE  3
`define RTB_CTRL_RST 4'h0
`endif
